/* core/subcode_params.svh */
/*
 * Constants for the subcode serial readout: field positions, sizes,
 * timing figures and reset values.
 * Assumes it is included by bare name from core/ sources.
 */
`ifndef SUBCODE_PARAMS_SVH
`define SUBCODE_PARAMS_SVH

`define CLK_PERIOD_NS     8
`define SUBCODE_FRAME_SYNC_HIGH_NS      4000
`define SUBCODE_FRAME_SYNC_HIGH_CYC     ((`SUBCODE_FRAME_SYNC_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUBCODE_SHIFT_CLOCK_WINDOW_NS    136000
`define SUBCODE_SHIFT_CLOCK_WINDOW_CYC   (`SUBCODE_SHIFT_CLOCK_WINDOW_NS / `CLK_PERIOD_NS)
`define SUB_BITS          8
`define SUB_P_POS         7
`define SUB_Q_POS         6
`define Q_DATA_BITS       80
`define Q_FRAME_BITS      96
`define Q_CRC_BITS        16
`define Q_CRC_POLY        16'h1021
`define Q_CRC_INIT        16'h0000
`define OUT_RESET_LEVEL   1'b0

`endif

/* core/subcode_pkg.sv */
/*
 * Types shared by the subcode readout modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package subcode_pkg;

    typedef enum logic [1:0] {
        FR_IDLE   = 2'b00,
        FR_SYNC   = 2'b01,
        FR_WINDOW = 2'b10
    } frame_state_t;

endpackage

/* core/q_crc_check.sv */
/*
 * Serial CRC-16 accumulator for the subcode Q channel.
 * Assumes bits arrive one per enable, first bit first, on clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "subcode_params.svh"

module q_crc_check (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // bit stream
    input  wire logic        clear,
    input  wire logic        bitEn,
    input  wire logic        bitIn,
    // running remainder
    output logic [15:0]      crc
);
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    always_comb begin
        crc_nxt = crc_r;
        if (clear) begin
            crc_nxt = `Q_CRC_INIT;
        end else if (bitEn) begin
            crc_nxt = {crc_r[14:0], 1'b0};
            if (crc_r[15] ^ bitIn) begin
                crc_nxt = crc_nxt ^ `Q_CRC_POLY;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            crc_r <= `Q_CRC_INIT;
        end else begin
            crc_r <= crc_nxt;
        end
    end

    assign crc = crc_r;
endmodule
`default_nettype wire

/* core/subcode_serial_readout.sv */
/*
 * Subcode serial readout: frame and block sync outputs, P..W serial
 * output clocked by the controller, and CRC-checked Q serial output.
 * Assumes subcode symbols arrive from the demodulator on clk, one
 * pulse per frame, with S0/S1 flags; shift clocks and the bit order
 * select come from pins and are resynchronised here.
 */
// What this block does
// - frame sync output marks each subcode frame
// - eight shift clocks yield P through W
// - block sync output marks each block start
// - Q ready rises only after CRC passes
// - order select low: Q least significant first
// - serial output changes on shift clock fall
// - P bit shown when no clock applied
// - block sync high during S0 and S1
`timescale 1ns/10ps
`default_nettype none
`include "subcode_params.svh"

module subcode_serial_readout
    import subcode_pkg::*;
#(
    parameter int SUBCODE_FRAME_SYNC_HIGH   = `SUBCODE_FRAME_SYNC_HIGH_CYC,
    parameter int SUBCODE_SHIFT_CLOCK_WINDOW = `SUBCODE_SHIFT_CLOCK_WINDOW_CYC,
    parameter int Q_BITS      = `Q_DATA_BITS
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // symbols from the demodulator
    input  wire logic        symValid,
    input  wire logic [7:0]  symData,
    input  wire logic        symIsS0,
    input  wire logic        symIsS1,
    // subcode pins
    input  wire logic        subcodeShiftClock,
    output logic             subcodeFrameSync,
    output logic             subcodeBlockSync,
    output logic             subcodeSerialOut,
    // q channel pins
    input  wire logic        qShiftClock,
    input  wire logic        qMsbFirst,
    output logic             qDataReady,
    output logic             qSerialOut
);
    localparam int WCNT_W = $clog2(SUBCODE_SHIFT_CLOCK_WINDOW + SUBCODE_FRAME_SYNC_HIGH + 1);
    localparam int QCNT_W = $clog2(`Q_FRAME_BITS + 1);

    function automatic logic qBitAt(input logic [Q_BITS-1:0] d,
                                    input logic [6:0] idx,
                                    input logic msb);
        qBitAt = msb ? d[Q_BITS-1-idx] : d[idx];
    endfunction

    // pin synchronisers; stage 3 is only the edge reference
    // reset to low so an idle-high clock never shows a false fall
    logic [2:0] sbckSync_r,  sbckSync_nxt;
    logic [2:0] cqckSync_r,  cqckSync_nxt;
    logic [1:0] orderSync_r, orderSync_nxt;

    always_comb begin
        sbckSync_nxt  = {sbckSync_r[1:0], subcodeShiftClock};
        cqckSync_nxt  = {cqckSync_r[1:0], qShiftClock};
        orderSync_nxt = {orderSync_r[0], qMsbFirst};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sbckSync_r  <= 3'h0;
            cqckSync_r  <= 3'h0;
            orderSync_r <= 2'h0;
        end else begin
            sbckSync_r  <= sbckSync_nxt;
            cqckSync_r  <= cqckSync_nxt;
            orderSync_r <= orderSync_nxt;
        end
    end
    wire logic sbckFall = sbckSync_r[2] & ~sbckSync_r[1];
    wire logic cqckFall = cqckSync_r[2] & ~cqckSync_r[1];

    // frame / P..W path
    frame_state_t       frSt_r,   frSt_nxt;
    logic [WCNT_W-1:0]  wCnt_r,   wCnt_nxt;
    logic [7:0]         pend_r,   pend_nxt;
    logic [7:0]         pwSh_r,   pwSh_nxt;
    logic [3:0]         pwCnt_r,  pwCnt_nxt;
    logic               subcode_frame_sync_r,   subcode_frame_sync_nxt;
    logic               pwOut_r,  pwOut_nxt;
    logic               subcode_block_sync_r,   subcode_block_sync_nxt;

    always_comb begin
        frSt_nxt  = frSt_r;
        wCnt_nxt  = wCnt_r;
        pend_nxt  = pend_r;
        pwSh_nxt  = pwSh_r;
        pwCnt_nxt = pwCnt_r;
        subcode_frame_sync_nxt  = subcode_frame_sync_r;
        pwOut_nxt = pwOut_r;
        subcode_block_sync_nxt  = subcode_block_sync_r;
        if (symValid) begin
            // a new frame restarts the sequence even if the last read lagged
            pend_nxt = symData;
            frSt_nxt = FR_SYNC;
            wCnt_nxt = '0;
            subcode_frame_sync_nxt = 1'b1;
            subcode_block_sync_nxt = symIsS0 | symIsS1;
        end else begin
            case (frSt_r)
                FR_SYNC: begin
                    wCnt_nxt = wCnt_r + 1'b1;
                    if (wCnt_r == WCNT_W'(SUBCODE_FRAME_SYNC_HIGH - 1)) begin
                        subcode_frame_sync_nxt  = 1'b0;
                        pwSh_nxt  = pend_r;
                        pwOut_nxt = pend_r[`SUB_P_POS];
                        pwCnt_nxt = 4'h0;
                        wCnt_nxt  = '0;
                        frSt_nxt  = FR_WINDOW;
                    end
                end
                FR_WINDOW: begin
                    wCnt_nxt = wCnt_r + 1'b1;
                    // clocks past the eighth are ignored; the output stays low
                    if (sbckFall && pwCnt_r != 4'(`SUB_BITS)) begin
                        pwSh_nxt  = {pwSh_r[6:0], 1'b0};
                        pwOut_nxt = pwSh_r[`SUB_P_POS-1];
                        pwCnt_nxt = pwCnt_r + 1'b1;
                    end
                    if (wCnt_r == WCNT_W'(SUBCODE_SHIFT_CLOCK_WINDOW - 1)) begin
                        frSt_nxt = FR_IDLE;
                    end
                end
                default: begin
                    frSt_nxt = FR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            frSt_r  <= FR_IDLE;
            wCnt_r  <= '0;
            pend_r  <= 8'h00;
            pwSh_r  <= 8'h00;
            pwCnt_r <= 4'h0;
            subcode_frame_sync_r  <= `OUT_RESET_LEVEL;
            pwOut_r <= `OUT_RESET_LEVEL;
            subcode_block_sync_r  <= `OUT_RESET_LEVEL;
        end else begin
            frSt_r  <= frSt_nxt;
            wCnt_r  <= wCnt_nxt;
            pend_r  <= pend_nxt;
            pwSh_r  <= pwSh_nxt;
            pwCnt_r <= pwCnt_nxt;
            subcode_frame_sync_r  <= subcode_frame_sync_nxt;
            pwOut_r <= pwOut_nxt;
            subcode_block_sync_r  <= subcode_block_sync_nxt;
        end
    end

    // q assembly and check
    logic [`Q_FRAME_BITS-1:0] qAsm_r,  qAsm_nxt;
    logic [QCNT_W-1:0]        qCnt_r,  qCnt_nxt;
    logic                     qDone;
    logic                     crcClear;
    logic                     crcEn;
    logic [15:0]              crcVal;
    wire logic                qBit = symData[`SUB_Q_POS];

    always_comb begin
        qAsm_nxt = qAsm_r;
        qCnt_nxt = qCnt_r;
        qDone    = 1'b0;
        crcClear = 1'b0;
        crcEn    = 1'b0;
        if (symValid) begin
            if (symIsS0 | symIsS1) begin
                qCnt_nxt = '0;
                crcClear = 1'b1;
            end else if (qCnt_r != QCNT_W'(`Q_FRAME_BITS)) begin
                qAsm_nxt = {qAsm_r[`Q_FRAME_BITS-2:0], qBit};
                qCnt_nxt = qCnt_r + 1'b1;
                crcEn    = qCnt_r < QCNT_W'(Q_BITS);
                qDone    = qCnt_r == QCNT_W'(`Q_FRAME_BITS - 1);
            end
        end
    end

    // the stored check field is the inverted remainder
    wire logic crcOk = qDone &&
        (crcVal == ~qAsm_nxt[`Q_CRC_BITS-1:0]);

    q_crc_check u_crc (
        .clk   (clk),
        .rst   (rst),
        .clear (crcClear),
        .bitEn (crcEn),
        .bitIn (qBit),
        .crc   (crcVal)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            qAsm_r <= '0;
            qCnt_r <= QCNT_W'(`Q_FRAME_BITS);
        end else begin
            qAsm_r <= qAsm_nxt;
            qCnt_r <= qCnt_nxt;
        end
    end

    // q readout
    logic [Q_BITS-1:0] qData_r,  qData_nxt;
    logic [6:0]        qIdx_r,   qIdx_nxt;
    logic              qRd_r,    qRd_nxt;
    logic              wrq_r,    wrq_nxt;
    logic              sqo_r,    sqo_nxt;
    logic              qMsb_r,   qMsb_nxt;

    always_comb begin
        qData_nxt = qData_r;
        qIdx_nxt  = qIdx_r;
        qRd_nxt   = qRd_r;
        wrq_nxt   = wrq_r;
        sqo_nxt   = sqo_r;
        qMsb_nxt  = qMsb_r;
        if (cqckFall && (wrq_r || qRd_r)) begin
            // first clock fall ends the ready flag and starts the read
            wrq_nxt  = 1'b0;
            qRd_nxt  = 1'b1;
            qIdx_nxt = qIdx_r + 1'b1;
            sqo_nxt  = qBitAt(qData_r, qIdx_r + 1'b1, qMsb_r);
            if (qIdx_r == 7'(Q_BITS - 1)) begin
                qRd_nxt = 1'b0;
                sqo_nxt = 1'b0;
            end
        end else if (crcOk && !qRd_r) begin
            // a read in progress is never overwritten mid-word
            qData_nxt = qAsm_nxt[`Q_FRAME_BITS-1:`Q_CRC_BITS];
            qMsb_nxt  = orderSync_r[1];
            qIdx_nxt  = 7'h00;
            wrq_nxt   = 1'b1;
            sqo_nxt   = qBitAt(qData_nxt, 7'h00, qMsb_nxt);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            qData_r <= '0;
            qIdx_r  <= 7'h00;
            qRd_r   <= 1'b0;
            wrq_r   <= `OUT_RESET_LEVEL;
            sqo_r   <= `OUT_RESET_LEVEL;
            qMsb_r  <= 1'b0;
        end else begin
            qData_r <= qData_nxt;
            qIdx_r  <= qIdx_nxt;
            qRd_r   <= qRd_nxt;
            wrq_r   <= wrq_nxt;
            sqo_r   <= sqo_nxt;
            qMsb_r  <= qMsb_nxt;
        end
    end

    assign subcodeFrameSync = subcode_frame_sync_r;
    assign subcodeBlockSync = subcode_block_sync_r;
    assign subcodeSerialOut = pwOut_r;
    assign qDataReady       = wrq_r;
    assign qSerialOut       = sqo_r;
endmodule
`default_nettype wire

/* dv/subcode_readout_checker.sv */
/*
 * Port checker for subcode_serial_readout.
 * Assumes one clk domain and the bind at the foot of this file.
 */
`timescale 1ns/10ps
`default_nettype none
module subcode_readout_checker #(
    parameter int SUBCODE_FRAME_SYNC_HIGH = 4
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // symbols
    input wire logic       symValid,
    input wire logic [7:0] symData,
    input wire logic       symIsS0,
    input wire logic       symIsS1,
    // pins
    input wire logic       subcodeShiftClock,
    input wire logic       subcodeFrameSync,
    input wire logic       subcodeBlockSync,
    input wire logic       subcodeSerialOut,
    input wire logic       qShiftClock,
    input wire logic       qDataReady
);
    logic [15:0] hiCnt_r, hiCnt_nxt;
    logic        pBit_r, pBit_nxt, sFlag_r, sFlag_nxt;
    always_comb begin
        hiCnt_nxt = (rst || !subcodeFrameSync) ? 16'h0000 : hiCnt_r + 16'h0001;
        pBit_nxt  = symValid ? symData[7] : pBit_r;
        sFlag_nxt = symValid ? (symIsS0 | symIsS1) : sFlag_r;
    end
    always_ff @(posedge clk) begin
        hiCnt_r <= hiCnt_nxt;
        pBit_r  <= pBit_nxt;
        sFlag_r <= sFlag_nxt;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence qFall;
        $fell(qShiftClock);
    endsequence
    // pin passes two sync flops and an edge register first
    sequence shFallSeen;
        ($past(subcodeShiftClock, 4) && !$past(subcodeShiftClock, 3)) or
        ($past(subcodeShiftClock, 5) && !$past(subcodeShiftClock, 4));
    endsequence
    a_sync_rise:
        assert property (symValid |-> ##[1:2] subcodeFrameSync)
        else $error("frame sync missing");
    a_sync_width:
        assert property ($fell(subcodeFrameSync) |-> hiCnt_r == SUBCODE_FRAME_SYNC_HIGH)
        else $error("frame sync width wrong");
    a_block_set:
        assert property ($rose(subcodeFrameSync) |-> subcodeBlockSync == sFlag_r)
        else $error("block sync level wrong");
    a_block_hold:
        assert property (!symValid && !$past(symValid) && !$past(symValid, 2)
                         |-> $stable(subcodeBlockSync))
        else $error("block sync moved between symbols");
    a_p_shown:
        assert property ($fell(subcodeFrameSync) |-> subcodeSerialOut == pBit_r)
        else $error("p bit not shown at sync fall");
    a_serial_on_fall:
        assert property ($changed(subcodeSerialOut)
                         |-> $fell(subcodeFrameSync) or shFallSeen)
        else $error("serial out moved without clock fall");
    a_ready_drop:
        assert property (qDataReady ##0 qFall |-> ##[3:4] !qDataReady)
        else $error("ready stayed after read began");
    a_ready_cause:
        assert property ($rose(qDataReady) |-> $past(symValid) || $past(symValid, 2))
        else $error("ready rose without a symbol");
endmodule
bind subcode_serial_readout subcode_readout_checker #(.SUBCODE_FRAME_SYNC_HIGH(SUBCODE_FRAME_SYNC_HIGH)) chk (
    .clk(clk), .rst(rst), .symValid(symValid), .symData(symData),
    .symIsS0(symIsS0), .symIsS1(symIsS1),
    .subcodeShiftClock(subcodeShiftClock), .subcodeFrameSync(subcodeFrameSync),
    .subcodeBlockSync(subcodeBlockSync), .subcodeSerialOut(subcodeSerialOut),
    .qShiftClock(qShiftClock), .qDataReady(qDataReady));
`default_nettype wire

/* dv/subcode_reader_model.sv */
/*
 * Controller model: reads P..W after each frame sync and the Q word
 * after ready rises. Assumes 125 ns shift clocks, idle high.
 */
`timescale 1ns/10ps
`default_nettype none
module subcode_reader_model (
    // from the block; msbFirst and slow from the bench
    input  wire logic   frameSync,
    input  wire logic   serialOut,
    input  wire logic   qReady,
    input  wire logic   qOut,
    input  wire logic   msbFirst,
    input  wire logic   slow,
    // shift clocks
    output logic        shiftClk,
    output logic        qClk,
    // what was read
    output logic [7:0]  subByte,
    output logic [79:0] qWord,
    output int          qCount
);
    initial begin
        shiftClk = 1'b1;
        qClk = 1'b1;
        qCount = 0;
    end
    // sample before each fall; slow start still ends far inside the window
    always @(posedge frameSync) begin
        @(negedge frameSync);
        if (slow) #200;
        repeat (8) begin
            #31 subByte = {subByte[6:0], serialOut};
            #31.5 shiftClk = 1'b0;
            #62.5 shiftClk = 1'b1;
        end
    end
    always @(posedge qReady) begin
        repeat (80) begin
            #31 qWord = msbFirst ? {qWord[78:0], qOut} : {qOut, qWord[79:1]};
            #31.5 qClk = 1'b0;
            #62.5 qClk = 1'b1;
        end
        qCount++;
    end
endmodule
`default_nettype wire

/* dv/testbench.sv */
/*
 * Self-checking bench for subcode_serial_readout.
 * Assumes the reader model drives both shift clock pins.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk, rst, symValid, symIsS0, symIsS1, qMsbFirst, slow;
    logic        shClk, qClk, fSync, bSync, sOut, qRdy, qOut;
    logic [7:0]  symData, subByte;
    logic [79:0] qWord, qData;
    int          qCount, prevQ, seed, cycles, miscompares, comparisons;
    always #4 clk = ~clk;
    subcode_serial_readout #(.SUBCODE_FRAME_SYNC_HIGH(4)) dut (
        .clk(clk), .rst(rst), .symValid(symValid), .symData(symData),
        .symIsS0(symIsS0), .symIsS1(symIsS1), .subcodeShiftClock(shClk),
        .subcodeFrameSync(fSync), .subcodeBlockSync(bSync),
        .subcodeSerialOut(sOut), .qShiftClock(qClk), .qMsbFirst(qMsbFirst),
        .qDataReady(qRdy), .qSerialOut(qOut));
    subcode_reader_model reader (
        .frameSync(fSync), .serialOut(sOut), .qReady(qRdy), .qOut(qOut),
        .msbFirst(qMsbFirst), .slow(slow), .shiftClk(shClk), .qClk(qClk),
        .subByte(subByte), .qWord(qWord), .qCount(qCount));
    task automatic check(string what, logic [79:0] exp, logic [79:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] crcOf(logic [79:0] d);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 79; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    task automatic frame(logic s0, logic s1, logic q);
        logic [7:0] d;
        d = 8'($random(seed));
        d[6] = q;
        @(negedge clk);
        symValid = 1'b1;
        symData = d;
        symIsS0 = s0;
        symIsS1 = s1;
        slow = 1'($random(seed));
        @(negedge clk);
        symValid = 1'b0;
        repeat (8) @(negedge clk);
        check("block sync", 80'(s0 | s1), 80'(bSync));
        repeat (200) @(negedge clk);
        check("subcode byte", 80'(d), 80'(subByte));
        check("serial idle", 80'h0, 80'(sOut));
    endtask
    // bad flips one check bit, so no word may be offered
    task automatic block(logic msb, logic bad);
        logic [15:0] c;
        qData = {$random(seed), $random(seed), 16'($random(seed))};
        c = ~crcOf(qData) ^ 16'(bad);
        qMsbFirst = msb;
        prevQ = qCount;
        frame(1'b1, 1'b0, 1'b0);
        frame(1'b0, 1'b1, 1'b0);
        for (int i = 95; i >= 0; i--)
            frame(1'b0, 1'b0, i >= 16 ? qData[i - 16] : c[i]);
        for (int n = 0; n < 2000 && qCount == prevQ; n++)
            @(negedge clk);
        check("q words read", 80'(!bad), 80'(qCount - prevQ));
        if (!bad)
            check("q word", qData, qWord);
        check("q pins idle", 80'h0, 80'({qRdy, qOut}));
    endtask
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        seed = 32'h2cb6_c00d;
        clk = 1'b0;
        rst = 1'b1;
        {symValid, symIsS0, symIsS1, qMsbFirst, slow} = 5'h00;
        symData = 8'h00;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        block(1'b0, 1'b0);
        block(1'b1, 1'b0);
        block(1'b0, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
